// ==== rtl/zsla_pkg.sv ====
// ****************************************************************
// Shared constants and carriers
// ****************************************************************
package zsla_pkg;
   // Per-zone or per-LED state triple
   typedef struct packed {
      logic alarm; // Alarm, or ancillary control zone operate
      logic fault; // Fault
      logic isolate; // Isolated
   } zsla_state_t;
   // First-network message header seen by the forwarder
   typedef struct packed {
      logic [7:0] dest; // Destination station identifier
      logic bcast; // Broadcast message
      logic [2:0] mtype; // Message type index
      logic [7:0] src; // Originating station identifier
   } zsla_msg_t;
   // Broadcast message types, one enable bit each
   localparam logic [2:0] MT_LINK_INTEGRITY = 3'h0;
   localparam logic [2:0] MT_ALARM_TOTALS_STATUS = 3'h1;
   localparam logic [2:0] MT_NETVAR = 3'h2;
   localparam logic [2:0] MT_FFCIF = 3'h3;
   localparam logic [2:0] MT_STATUS_XFER = 3'h4;
   localparam logic [2:0] MT_EVENT = 3'h5;
   localparam int MT_COUNT = 6;
   // Register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_LINK = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_TAB = 8'h20;
   // CFG field positions (0 = setting 1, 1 = setting 2 / flash yes)
   localparam int CFG_LOC_ALM = 0;
   localparam int CFG_LOC_FLT = 1;
   localparam int CFG_LOC_ISO = 2;
   localparam int CFG_LOC_FLASH = 3;
   localparam int CFG_REM_ALM = 4;
   localparam int CFG_REM_FLT = 5;
   localparam int CFG_REM_ISO = 6;
   localparam logic [6:0] CFG_RST = 7'h70;
   // LINK fields: [7:0] remote id, [8] link integrity send, [21:16] boards
   localparam int LINK_LI_EN = 8;
   localparam int LINK_BRD_LSB = 16;
   localparam logic [7:0] LINK_ID_RST = 8'h00;
   localparam logic [5:0] BOARDS_RST = 6'h21;
   localparam logic [5:0] BOARDS_MIN = 6'h01;
   localparam logic [5:0] BOARDS_MAX = 6'h21;
   localparam int LEDS_PER_BOARD_LOG2 = 4;
   // STAT fields: [0] rate exceeded (write 1 clears), [31:16] forwarded total
   localparam int STAT_RATE = 0;
   localparam int STAT_TOT_LSB = 16;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing
   localparam longint CLK_HZ = 40_000_000;
   localparam longint FLASH_HZ = 2;
   localparam int FLASH_HALF_CYC = int'(CLK_HZ / (2 * FLASH_HZ));
   localparam longint RATE_WIN_S = 1;
   localparam int RATE_WIN_CYC = int'(CLK_HZ * RATE_WIN_S);
   localparam logic [7:0] RATE_MAX = 8'h02;
   localparam longint LI_PERIOD_S = 8;
   localparam int LI_PERIOD_CYC = int'(CLK_HZ * LI_PERIOD_S);
endpackage

// ==== rtl/zsla_top.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module zsla_top #(
   parameter int NZONE = 64,
   parameter int NLED = 528,
   parameter int NSTN = 8,
   parameter int FLASH_HALF = zsla_pkg::FLASH_HALF_CYC,
   parameter int RATE_WIN = zsla_pkg::RATE_WIN_CYC,
   parameter int LI_PERIOD = zsla_pkg::LI_PERIOD_CYC
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input zsla_pkg::zsla_state_t zone_state [NZONE], // Per-zone states
   input wire logic [9:0] zone_led [NZONE], // LED number 1..528, 0 unmapped
   input zsla_pkg::zsla_msg_t n1_msg, // First-network message
   input wire logic n1_valid, // First-network message valid
   output logic n1_ready, // First-network message taken
   output zsla_pkg::zsla_msg_t n2_msg, // Message toward second network
   output logic n2_valid, // Second-network message valid
   input wire logic n2_ready, // Second-network message taken
   input wire logic n2_bcast_rx, // Broadcast received from remote panel
   output logic n2_ack, // Acknowledge to that broadcast
   output logic n2_li_tx, // Send own link integrity message
   output logic [NLED-1:0] loc_alarm, // Local alarm LEDs
   output logic [NLED-1:0] loc_fault, // Local fault LEDs
   output logic [NLED-1:0] loc_isolate, // Local isolate LEDs
   output logic [NLED-1:0] rem_alarm, // Remote output alarm states
   output logic [NLED-1:0] rem_fault, // Remote output fault states
   output logic [NLED-1:0] rem_isolate, // Remote output isolate states
   output logic [9:0] rem_count // Remote output entry count
);
   // ****************************************************************
   // Register bus slave
   // ****************************************************************
   logic [6:0] cfg_reg; // Seven global display settings
   logic [7:0] rem_id_reg; // Remote device station identifier
   logic li_en_reg; // Own link integrity enable
   logic [5:0] boards_reg; // Boards worth of remote output
   logic [15:0] tab_reg [NSTN]; // [7:0] station, [13:8] type enables
   logic rate_exc_reg; // Rate exceeded, sticky
   logic [15:0] fwd_tot_reg; // Forwarded message total
   logic aw_full_reg; // Write address held
   logic [7:0] aw_addr_reg; // Held write address
   logic w_full_reg; // Write data held
   logic [31:0] w_data_reg; // Held write data
   logic [3:0] w_strb_reg; // Held write strobes
   logic bvalid_reg; // Write response pending
   logic [1:0] bresp_reg; // Write response code
   logic rvalid_reg; // Read data pending
   logic [31:0] rdata_reg; // Read data
   logic [1:0] rresp_reg; // Read response code
   // Handshake decode
   wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   wire rd_take = s_axi_arvalid && !rvalid_reg;
   wire [5:0] w_idx = aw_addr_reg[7:2];
   wire [5:0] r_idx = s_axi_araddr[7:2];
   wire [5:0] tab_idx0 = zsla_pkg::OFS_TAB[7:2];
   wire w_cfg = w_idx == zsla_pkg::OFS_CFG[7:2];
   wire w_link = w_idx == zsla_pkg::OFS_LINK[7:2];
   wire w_stat = w_idx == zsla_pkg::OFS_STAT[7:2];
   wire w_tab = w_idx >= tab_idx0 && w_idx < tab_idx0 + 6'(NSTN);
   wire w_ok = w_cfg || w_link || w_stat || w_tab;
   wire [5:0] w_tab_sel = w_idx - tab_idx0;
   wire [5:0] r_tab_sel = r_idx - tab_idx0;
   wire r_tab = r_idx >= tab_idx0 && r_idx < tab_idx0 + 6'(NSTN);
   wire rate_clr = do_write && w_stat && w_strb_reg[0] && w_data_reg[zsla_pkg::STAT_RATE];
   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   // Read data multiplexer
   logic [31:0] r_mux;
   logic r_ok;
   always_comb begin
      r_mux = 32'h0000_0000;
      r_ok = 1'b1;
      if (r_idx == zsla_pkg::OFS_CFG[7:2]) begin
         r_mux[6:0] = cfg_reg;
      end else if (r_idx == zsla_pkg::OFS_LINK[7:2]) begin
         r_mux = {10'h000, boards_reg, 7'h00, li_en_reg, rem_id_reg};
      end else if (r_idx == zsla_pkg::OFS_STAT[7:2]) begin
         r_mux = {fwd_tot_reg, 15'h0000, rate_exc_reg};
      end else if (r_tab) begin
         r_mux[15:0] = tab_reg[r_tab_sel[$clog2(NSTN)-1:0]];
      end else begin
         r_ok = 1'b0;
      end
   end
   // Address and data channels are captured independently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= zsla_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full_reg <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_reg <= 1'b0;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_ok ? zsla_pkg::RESP_OKAY : zsla_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   // Read channel, answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= zsla_pkg::RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= r_mux;
         rresp_reg <= r_ok ? zsla_pkg::RESP_OKAY : zsla_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   // Settings registers, defaults applied at reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= zsla_pkg::CFG_RST;
         rem_id_reg <= zsla_pkg::LINK_ID_RST;
         li_en_reg <= 1'b0;
         boards_reg <= zsla_pkg::BOARDS_RST;
      end else if (do_write && w_cfg && w_strb_reg[0]) begin
         cfg_reg <= w_data_reg[6:0];
      end else if (do_write && w_link) begin
         if (w_strb_reg[0]) rem_id_reg <= w_data_reg[7:0];
         if (w_strb_reg[1]) li_en_reg <= w_data_reg[zsla_pkg::LINK_LI_EN];
         if (w_strb_reg[2]) boards_reg <= w_data_reg[zsla_pkg::LINK_BRD_LSB +: 6];
      end
   end
   // Per-station broadcast enable table
   for (genvar s = 0; s < NSTN; s++) begin : g_tab
      wire hit = do_write && w_tab && w_tab_sel == 6'(s);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            tab_reg[s] <= 16'h0000;
         end else if (hit) begin
            if (w_strb_reg[0]) tab_reg[s][7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) tab_reg[s][15:8] <= {2'h0, w_data_reg[13:8]};
         end
      end
   end
   // ****************************************************************
   // Flash timebase
   // ****************************************************************
   logic [31:0] flash_cnt_reg; // Half period counter
   logic flash_reg; // Square wave, half duty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg <= 1'b0;
      end else if (flash_cnt_reg == 32'(FLASH_HALF - 1)) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg <= !flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
   end
   // ****************************************************************
   // Zone to LED aggregation
   // ****************************************************************
   wire [NLED-1:0] la_next, lf_next, li_next, ra_next, rf_next, ri_next;
   logic [NLED-1:0] mapped_w; // LED has a mapped zone
   wire [5:0] brd_clamp = boards_reg < zsla_pkg::BOARDS_MIN ? zsla_pkg::BOARDS_MIN :
                          boards_reg > zsla_pkg::BOARDS_MAX ? zsla_pkg::BOARDS_MAX : boards_reg;
   wire [9:0] count_w = {brd_clamp, 4'h0};
   for (genvar l = 0; l < NLED; l++) begin : g_led
      logic am, ani, fm, fni, im, ia, mp;
      // Gather every zone that names this LED
      always_comb begin
         am = 1'b0;
         ani = 1'b0;
         fm = 1'b0;
         fni = 1'b0;
         im = 1'b0;
         ia = 1'b1;
         mp = 1'b0;
         for (int z = 0; z < NZONE; z++) begin
            if (zone_led[z] == 10'(l + 1)) begin
               mp = 1'b1;
               am = am | zone_state[z].alarm;
               ani = ani | (zone_state[z].alarm & !zone_state[z].isolate);
               fm = fm | zone_state[z].fault;
               fni = fni | (zone_state[z].fault & !zone_state[z].isolate);
               im = im | zone_state[z].isolate;
               ia = ia & zone_state[z].isolate;
            end
         end
         if (!mp) ia = 1'b0;
      end
      assign mapped_w[l] = mp;
      assign la_next[l] = cfg_reg[zsla_pkg::CFG_LOC_ALM] ? ani : am;
      assign lf_next[l] = cfg_reg[zsla_pkg::CFG_LOC_FLT] ? fni : fm;
      assign li_next[l] = !cfg_reg[zsla_pkg::CFG_LOC_ISO] ? im :
                          ia | (cfg_reg[zsla_pkg::CFG_LOC_FLASH] & im & flash_reg);
      assign ra_next[l] = cfg_reg[zsla_pkg::CFG_REM_ALM] ? ani : am;
      assign rf_next[l] = cfg_reg[zsla_pkg::CFG_REM_FLT] ? fni : fm;
      assign ri_next[l] = (cfg_reg[zsla_pkg::CFG_REM_ISO] ? ia : im)
                          && 10'(l) < count_w;
   end
   // Display outputs, refreshed every cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loc_alarm <= '0;
         loc_fault <= '0;
         loc_isolate <= '0;
         rem_alarm <= '0;
         rem_fault <= '0;
         rem_isolate <= '0;
         rem_count <= 10'h000;
      end else begin
         loc_alarm <= la_next;
         loc_fault <= lf_next;
         loc_isolate <= li_next;
         rem_alarm <= ra_next & rem_mask(count_w);
         rem_fault <= rf_next & rem_mask(count_w);
         rem_isolate <= ri_next;
         rem_count <= count_w;
      end
   end
   // Entries beyond the remote count are sent as off
   function automatic logic [NLED-1:0] rem_mask(input logic [9:0] n);
      logic [NLED-1:0] m;
      m = '0;
      for (int i = 0; i < NLED; i++) m[i] = 10'(i) < n;
      return m;
   endfunction
   // ****************************************************************
   // Second network forwarding
   // ****************************************************************
   logic [NSTN-1:0] en_hit; // Station enables this broadcast type
   for (genvar s = 0; s < NSTN; s++) begin : g_en
      assign en_hit[s] = tab_reg[s][7:0] == n1_msg.src && tab_reg[s][8 + n1_msg.mtype];
   end
   wire direct = !n1_msg.bcast && n1_msg.dest == rem_id_reg;
   wire type_ok = n1_msg.mtype < 3'(zsla_pkg::MT_COUNT);
   wire bc_ok = n1_msg.bcast && type_ok && |en_hit;
   wire n1_take = n1_valid && n1_ready;
   wire fwd = n1_take && (direct || bc_ok);
   logic n2_valid_reg; // Output message pending
   assign n1_ready = !n2_valid_reg || n2_ready;
   assign n2_valid = n2_valid_reg;
   // Single-entry output holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         n2_valid_reg <= 1'b0;
         n2_msg <= '0;
      end else if (fwd) begin
         n2_valid_reg <= 1'b1;
         n2_msg <= n1_msg;
      end else if (n2_ready) begin
         n2_valid_reg <= 1'b0;
      end
   end
   // Broadcast acknowledge from the unit itself
   always_ff @(posedge aclk) begin
      if (!aresetn) n2_ack <= 1'b0;
      else n2_ack <= n2_bcast_rx;
   end
   // Own link integrity pulse, period LI_PERIOD counting the pulse cycle itself
   logic [31:0] li_cnt_reg; // Link integrity period counter
   always_ff @(posedge aclk) begin
      if (!aresetn || !li_en_reg) begin
         li_cnt_reg <= 32'h0000_0000;
         n2_li_tx <= 1'b0;
      end else begin
         n2_li_tx <= li_cnt_reg == 32'(LI_PERIOD - 2);
         li_cnt_reg <= n2_li_tx ? 32'h0000_0000 : li_cnt_reg + 32'h0000_0001;
      end
   end
   // Forwarded rate watch over one-second windows
   logic [31:0] win_cnt_reg; // Window counter
   logic [7:0] win_fwd_reg; // Messages in this window
   wire win_end = win_cnt_reg == 32'(RATE_WIN - 1);
   wire rate_set = win_end && win_fwd_reg > zsla_pkg::RATE_MAX;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_cnt_reg <= 32'h0000_0000;
         win_fwd_reg <= 8'h00;
         fwd_tot_reg <= 16'h0000;
         rate_exc_reg <= 1'b0;
      end else begin
         win_cnt_reg <= win_end ? 32'h0000_0000 : win_cnt_reg + 32'h0000_0001;
         if (win_end) win_fwd_reg <= {7'h00, fwd};
         else if (fwd && win_fwd_reg != 8'hFF) win_fwd_reg <= win_fwd_reg + 8'h01;
         if (fwd) fwd_tot_reg <= fwd_tot_reg + 16'h0001;
         if (rate_set) rate_exc_reg <= 1'b1;
         else if (rate_clr) rate_exc_reg <= 1'b0;
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_direct_in;
      n1_take && !n1_msg.bcast && n1_msg.dest == rem_id_reg;
   endsequence
   sequence s_out_holds(logic [7:0] d);
      n2_valid && n2_msg.dest == d;
   endsequence
   property p_direct;
      logic [7:0] d;
      @(posedge aclk) disable iff (!aresetn)
      (s_direct_in, d = n1_msg.dest) |=> s_out_holds(d);
   endproperty
   a_direct: assert property (p_direct) else $error("direct message lost");
   property p_bcast_block;
      @(posedge aclk) disable iff (!aresetn)
      n1_take && n1_msg.bcast && !(|en_hit) && !n2_valid |=> !n2_valid;
   endproperty
   a_bcast_block: assert property (p_bcast_block) else $error("disabled broadcast sent");
   property p_ack;
      @(posedge aclk) disable iff (!aresetn)
      n2_bcast_rx |=> n2_ack ##1 (n2_ack == $past(n2_bcast_rx));
   endproperty
   a_ack: assert property (p_ack) else $error("broadcast not acknowledged");
   property p_defaults;
      @(posedge aclk) $rose(aresetn) |-> cfg_reg == zsla_pkg::CFG_RST;
   endproperty
   a_defaults: assert property (p_defaults) else $error("wrong default settings");
   property p_count;
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> rem_count >= 10'd16 && rem_count <= 10'd528;
   endproperty
   a_count: assert property (p_count) else $error("remote count out of range");
   property p_flash_period;
      @(posedge aclk) disable iff (!aresetn)
      $changed(flash_reg) |=> $stable(flash_reg) && flash_cnt_reg == 32'h0000_0001;
   endproperty
   a_flash_period: assert property (p_flash_period) else $error("flash phase error");
   property p_unmapped;
      @(posedge aclk) disable iff (!aresetn)
      !mapped_w[3] |=> !loc_alarm[3] && !loc_fault[3] && !loc_isolate[3] && !rem_isolate[3];
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped LED lit");
   property p_loc_alarm;
      @(posedge aclk) disable iff (!aresetn)
      !cfg_reg[zsla_pkg::CFG_LOC_ALM] && g_led[0].am |=> loc_alarm[0];
   endproperty
   a_loc_alarm: assert property (p_loc_alarm) else $error("local alarm missed");
   property p_rem_iso_all;
      @(posedge aclk) disable iff (!aresetn)
      cfg_reg[zsla_pkg::CFG_REM_ISO] && g_led[0].im && !g_led[0].ia |=> !rem_isolate[0];
   endproperty
   a_rem_iso_all: assert property (p_rem_iso_all) else $error("partial isolate sent");
   property p_li_off;
      @(posedge aclk) disable iff (!aresetn)
      !li_en_reg |=> !n2_li_tx;
   endproperty
   a_li_off: assert property (p_li_off) else $error("link integrity while disabled");
   property p_rate;
      @(posedge aclk) disable iff (!aresetn)
      rate_set |=> rate_exc_reg [*2];
   endproperty
   a_rate: assert property (p_rate) else $error("rate flag not held");
endmodule

// ==== testbench/zone_state_led_aggregator_bench.sv ====
`timescale 1ns/1ps
module zone_state_led_aggregator_bench;
   localparam int NZ = 8;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, n1_valid = 0, n2_bcast_rx = 0, slow = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, n1_ready;
   logic n2_valid, n2_ready, n2_ack, n2_li_tx;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_cnt;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, r = 32'h0000_bbcf;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rp;
   logic [9:0] rem_count, zone_led [NZ];
   logic [527:0] loc_alarm, loc_fault, loc_isolate, rem_alarm, rem_fault, rem_isolate;
   zsla_pkg::zsla_state_t zone_state [NZ];
   zsla_pkg::zsla_msg_t n1_msg = '0, n2_msg, last;
   int n_fail = 0, compares = 0;
   zsla_top #(.NZONE(NZ), .NSTN(2), .FLASH_HALF(4), .RATE_WIN(20), .LI_PERIOD(10))
      u_zsla_top (.*);
   zsla_n2_model u_zsla_n2_model (.aclk(aclk), .aresetn(aresetn), .slow(slow),
      .n2_msg(n2_msg), .n2_valid(n2_valid), .n2_ready(n2_ready), .last_reg(last),
      .rx_cnt_reg(rx_cnt));
   always #12.5 aclk = ~aclk;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // AXI write: each channel released when taken, wait for response
   task automatic axw(logic [7:0] a, logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task automatic axr(logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Expected {local a,f,i, remote a,f,i} for one LED
   function automatic logic [5:0] exp_led(int l, logic [6:0] c);
      logic aa = 0, an = 0, fa = 0, fn = 0, ia = 0, il = 1, hit = 0;
      for (int i = 0; i < NZ; i++) begin
         if (zone_led[i] == l) begin
            hit = 1;
            aa |= zone_state[i].alarm;
            an |= zone_state[i].alarm & !zone_state[i].isolate;
            fa |= zone_state[i].fault;
            fn |= zone_state[i].fault & !zone_state[i].isolate;
            ia |= zone_state[i].isolate;
            il &= zone_state[i].isolate;
         end
      end
      il &= hit;
      return {c[0] ? an : aa, c[1] ? fn : fa, c[2] ? il : ia, c[4] ? an : aa, c[5] ? fn : fa,
         c[6] ? il : ia};
   endfunction
   initial begin
      logic [6:0] c;
      int k, n, p, nf;
      logic fw;
      zsla_pkg::zsla_msg_t m;
      for (int i = 0; i < NZ; i++) begin
         zone_led[i] = (i < 6) ? 10'(i % 3 + 1) : 10'h000;
         zone_state[i] = '0;
      end
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      axr(zsla_pkg::OFS_CFG);
      chk("cfg", 32'h0000_0070, rd);
      chk("count", 32'h0000_0210, {22'h0, rem_count});
      axr(8'h1c);
      chk("resp", {30'h0, zsla_pkg::RESP_SLVERR}, {30'h0, rp});
      // Random settings and zone states, LEDs 1..3 shared, 4 unmapped
      for (k = 0; k < 24; k++) begin
         r = lfsr(r);
         c = r[6:0] & 7'h77;
         axw(zsla_pkg::OFS_CFG, {25'h0, c});
         for (int i = 0; i < NZ; i++) zone_state[i] <= r[i * 3 + 7 +: 3];
         repeat (3) @(posedge aclk);
         for (int l = 1; l <= 4; l++) chk("led", {26'h0, exp_led(l, c)}, {26'h0,
            loc_alarm[l-1], loc_fault[l-1], loc_isolate[l-1], rem_alarm[l-1],
            rem_fault[l-1], rem_isolate[l-1]});
      end
      // Partial isolate flashes, full isolate steady
      axw(zsla_pkg::OFS_CFG, 32'h0000_000c);
      for (int i = 0; i < NZ; i++) zone_state[i] <= {2'b00, i == 0};
      for (k = 0; k < 2; k++) begin
         if (k == 1) zone_state[3] <= 3'b001;
         repeat (4) @(posedge aclk);
         n = 0;
         repeat (16) begin
            @(posedge aclk);
            n += loc_isolate[0];
         end
         chk("flash", 32'(8 + 8 * k), n);
      end
      axw(zsla_pkg::OFS_LINK, 32'h0000_0105);
      axw(zsla_pkg::OFS_TAB, 32'h0000_0211);
      // Direct and broadcast messages, far side stalling at random
      for (k = 0; k < 16; k++) begin
         r = lfsr(r);
         m = r[19:0];
         m.bcast = k[0];
         if (k[1]) m.dest = 8'h05;
         if (k[2]) m.src = 8'h11;
         if (k[3]) m.mtype = 3'h1;
         slow <= r[20];
         p = rx_cnt;
         n1_msg <= m;
         n1_valid <= 1;
         do @(posedge aclk); while (!n1_ready);
         n1_valid <= 0;
         repeat (8) @(posedge aclk);
         fw = (!m.bcast && m.dest == 8'h05) || (m.bcast && m.src == 8'h11 && m.mtype == 3'h1);
         nf += fw;
         chk("fwd", 32'(p + fw), 32'(rx_cnt));
         if (fw) chk("msg", 32'(m), 32'(last));
      end
      // Six direct messages back to back overrun any window, write 1 clears the flag
      slow <= 0;
      m.bcast = 0;
      m.dest = 8'h05;
      n1_msg <= m;
      n1_valid <= 1;
      repeat (6) @(posedge aclk);
      n1_valid <= 0;
      repeat (45) @(posedge aclk);
      axr(zsla_pkg::OFS_STAT);
      chk("stat", 32'(nf + 6) << 16 | 32'h0000_0001, rd);
      axw(zsla_pkg::OFS_STAT, 32'h0000_0001);
      axr(zsla_pkg::OFS_STAT);
      chk("clr", 32'(nf + 6) << 16, rd);
      n = 0;
      repeat (30) begin
         @(posedge aclk);
         n += n2_li_tx;
      end
      chk("li", 32'h0000_0003, n);
      n2_bcast_rx <= 1;
      @(posedge aclk);
      n2_bcast_rx <= 0;
      #1 chk("ack", 32'h0000_0001, {31'h0, n2_ack});
      @(posedge aclk);
      axw(zsla_pkg::OFS_LINK, 32'h0001_0105);
      repeat (2) @(posedge aclk);
      chk("count", 32'h0000_0010, {22'h0, rem_count});
      print_verdict();
   end
   initial begin
      #(25 * 20000);
      n_fail++;
      print_verdict();
   end
endmodule

// ==== testbench/zsla_n2_model.sv ====
`timescale 1ns/1ps
// Far-side panel: takes forwarded messages, promptly or with stalls
module zsla_n2_model (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic slow, // Stall mode, ready one cycle in four
   input zsla_pkg::zsla_msg_t n2_msg, // Forwarded message
   input wire logic n2_valid, // Message valid
   output logic n2_ready, // Message taken
   output zsla_pkg::zsla_msg_t last_reg, // Last message taken
   output logic [7:0] rx_cnt_reg // Messages taken
);
   logic [1:0] cnt_reg; // Stall phase
   // Single full-duplex receiver, never shared
   assign n2_ready = !slow || cnt_reg == 2'h3;
   // Record each accepted message
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 2'h0;
         rx_cnt_reg <= 8'h00;
         last_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         if (n2_valid && n2_ready) begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
            last_reg <= n2_msg;
         end
      end
   end
endmodule
